/* File: rtl/ssf_pkg.sv */
package ssf_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PAD_CTRL    = 8'h12;
  localparam logic [7:0] ADDR_FIFO_CTRL   = 8'h13;
  localparam logic [7:0] ADDR_FIFO_THR    = 8'h14;
  localparam logic [7:0] ADDR_LEVEL_STAT  = 8'h25;
  localparam logic [7:0] ADDR_FLAG_STAT   = 8'h26;
  localparam logic [7:0] ADDR_PRESS_XL    = 8'h28;
  localparam logic [7:0] ADDR_PRESS_L     = 8'h29;
  localparam logic [7:0] ADDR_PRESS_H     = 8'h2A;
  localparam logic [7:0] ADDR_TEMP_L      = 8'h2B;
  localparam logic [7:0] ADDR_TEMP_H      = 8'h2C;
  localparam logic [7:0] ADDR_FPRESS_XL   = 8'h78;
  localparam logic [7:0] ADDR_FPRESS_L    = 8'h79;
  localparam logic [7:0] ADDR_FPRESS_H    = 8'h7A;
  localparam logic [7:0] ADDR_FTEMP_L     = 8'h7B;
  localparam logic [7:0] ADDR_FTEMP_H     = 8'h7C;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int         PAD_OVR_BIT      = 2;
  localparam int         PAD_THR_BIT      = 3;
  localparam int         PAD_FULL_BIT     = 4;
  localparam int         PAD_DRDY_BIT     = 5;
  localparam int         CTRL_TRIG_BIT    = 2;
  localparam int         CTRL_STOP_BIT    = 3;
  localparam int         STAT_FULL_BIT    = 5;
  localparam int         STAT_OVR_BIT     = 6;
  localparam int         STAT_THR_BIT     = 7;
  localparam logic [7:0] PAD_CTRL_RST     = 8'h00;
  localparam logic [7:0] FIFO_CTRL_RST    = 8'h00;
  localparam logic [7:0] FIFO_THR_RST     = 8'h00;

  // ----------------------------------------------------------------
  // Sizes and mode codes
  // ----------------------------------------------------------------
  localparam int         DEPTH            = 128;
  localparam int         ENTRY_W          = 40;
  localparam logic [7:0] COUNT_FULL       = 8'h80;
  localparam int         TRIM_WORDS       = 4;
  localparam logic [2:0] CODE_BYPASS      = 3'h0;
  localparam logic [2:0] CODE_STOP        = 3'h1;
  localparam logic [2:0] CODE_CONT        = 3'h3;
  localparam logic [2:0] CODE_BYP_STOP    = 3'h5;
  localparam logic [2:0] CODE_BYP_CONT    = 3'h6;
  localparam logic [2:0] CODE_CONT_STOP   = 3'h7;

  typedef enum logic [1:0] {
    MODE_BYPASS,
    MODE_STOP,
    MODE_CONT
  } ssf_mode_e;

endpackage

/* File: rtl/ssf_entry_mem.sv */
`timescale 1ns/1ns
module ssf_entry_mem (
  // Clock
  input  wire logic                        clk_i,
  // Write port
  input  wire logic                        wr_en_i,
  input  wire logic [6:0]                  wr_addr_i,
  input  wire logic [ssf_pkg::ENTRY_W-1:0] wr_data_i,
  // Read port
  input  wire logic [6:0]                  rd_addr_i,
  output logic      [ssf_pkg::ENTRY_W-1:0] rd_data_o
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // No reset: contents are meaningless until the level counter covers them
  logic [ssf_pkg::ENTRY_W-1:0] mem [ssf_pkg::DEPTH];

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  assign rd_data_o = mem[rd_addr_i];

endmodule

/* File: rtl/ssf_top.sv */
`timescale 1ns/1ns
module ssf_top (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // Measurement results
  input  wire logic        sample_valid_i,
  input  wire logic [23:0] sample_pressure_i,
  input  wire logic [15:0] sample_temperature_i,
  input  wire logic        interrupt_active_flag_i,
  // Trimming storage
  output logic      [1:0]  trim_addr_o,
  input  wire logic [7:0]  trim_data_i,
  output logic             trim_done_o,
  output logic      [31:0] trim_value_o,
  // Register port from the serial interface
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_burst_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  // Pad
  output logic             ready_interrupt_pad_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic {
    TRIM_LOAD,
    TRIM_IDLE
  } ssf_trim_e;

  ssf_trim_e          trim_state_reg;
  logic [2:0]         trim_cnt_reg;
  logic [7:0]         pad_ctrl_reg;
  logic [7:0]         fifo_ctrl_reg;
  logic [7:0]         fifo_thr_reg;
  logic [23:0]        press_reg;
  logic [15:0]        temp_reg;
  logic               drdy_reg;
  logic               triggered_reg;
  logic               ovr_reg;
  logic [6:0]         wr_ptr_reg;
  logic [6:0]         rd_ptr_reg;
  logic [7:0]         count_reg;
  logic [7:0]         next_addr_reg;
  logic [7:0]         acc_addr;
  logic [2:0]         code;
  logic               accept;
  logic               pop;
  logic               full;
  logic               at_limit;
  logic               push;
  logic               overwrite;
  logic               thr_flag;
  logic               fifo_clear;
  logic [7:0]         limit;
  logic [39:0]        head;
  logic [7:0]         rd_value;
  ssf_pkg::ssf_mode_e mode;

  // ----------------------------------------------------------------
  // Power-up trimming download
  // ----------------------------------------------------------------
  // Storage answers one cycle after the address; the address runs one ahead
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trim_state_reg <= TRIM_LOAD;
      trim_cnt_reg   <= 3'h0;
      trim_addr_o    <= 2'h0;
      trim_value_o   <= 32'h0;
      trim_done_o    <= 1'b0;
    end else begin
      unique case (trim_state_reg)
        TRIM_LOAD: begin
          trim_addr_o  <= trim_addr_o + 2'h1;
          trim_cnt_reg <= trim_cnt_reg + 3'h1;
          if (trim_cnt_reg != 3'h0) begin
            trim_value_o <= {trim_data_i, trim_value_o[31:8]};
          end
          if (trim_cnt_reg == 3'(ssf_pkg::TRIM_WORDS)) begin
            trim_state_reg <= TRIM_IDLE;
            trim_done_o    <= 1'b1;
          end
        end
        TRIM_IDLE: begin
          trim_addr_o <= 2'h0;
        end
      endcase
    end
  end

  // Results are held off until the trimming is in place
  assign accept = sample_valid_i && trim_done_o;

  // ----------------------------------------------------------------
  // Address handling and mode decode
  // ----------------------------------------------------------------
  assign acc_addr = reg_burst_i ? next_addr_reg : reg_addr_i;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      next_addr_reg <= 8'h00;
    end else if (reg_rd_i || reg_wr_i) begin
      if (acc_addr == ssf_pkg::ADDR_FTEMP_H) begin
        next_addr_reg <= ssf_pkg::ADDR_FPRESS_XL;
      end else begin
        next_addr_reg <= acc_addr + 8'h01;
      end
    end
  end

  assign code = {fifo_ctrl_reg[ssf_pkg::CTRL_TRIG_BIT], fifo_ctrl_reg[1:0]};

  always_comb begin
    unique case (code)
      ssf_pkg::CODE_STOP:      mode = ssf_pkg::MODE_STOP;
      ssf_pkg::CODE_CONT:      mode = ssf_pkg::MODE_CONT;
      ssf_pkg::CODE_BYP_STOP:  mode = triggered_reg ? ssf_pkg::MODE_STOP : ssf_pkg::MODE_BYPASS;
      ssf_pkg::CODE_BYP_CONT:  mode = triggered_reg ? ssf_pkg::MODE_CONT : ssf_pkg::MODE_BYPASS;
      ssf_pkg::CODE_CONT_STOP: mode = triggered_reg ? ssf_pkg::MODE_STOP : ssf_pkg::MODE_CONT;
      default:                 mode = ssf_pkg::MODE_BYPASS;
    endcase
  end

  // A control value of zero leaves the FIFO disabled and empty
  assign fifo_clear = (mode == ssf_pkg::MODE_BYPASS);

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pad_ctrl_reg  <= ssf_pkg::PAD_CTRL_RST;
      fifo_ctrl_reg <= ssf_pkg::FIFO_CTRL_RST;
      fifo_thr_reg  <= ssf_pkg::FIFO_THR_RST;
    end else if (reg_wr_i) begin
      if (acc_addr == ssf_pkg::ADDR_PAD_CTRL) begin
        pad_ctrl_reg <= reg_wdata_i;
      end
      if (acc_addr == ssf_pkg::ADDR_FIFO_CTRL) begin
        fifo_ctrl_reg <= reg_wdata_i;
      end
      if (acc_addr == ssf_pkg::ADDR_FIFO_THR) begin
        fifo_thr_reg <= {1'b0, reg_wdata_i[6:0]};
      end
    end
  end

  // Trigger latch: set in any cycle the active flag is high while the trigger bit is set, undone by any new mode write
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      triggered_reg <= 1'b0;
    end else if (reg_wr_i && acc_addr == ssf_pkg::ADDR_FIFO_CTRL) begin
      triggered_reg <= 1'b0;
    end else if (interrupt_active_flag_i && code[2]) begin
      triggered_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Direct output registers and data-ready
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      press_reg <= 24'h0;
      temp_reg  <= 16'h0;
    end else if (accept) begin
      press_reg <= sample_pressure_i;
      temp_reg  <= sample_temperature_i;
    end
  end

  // New sample wins over the clearing read in the same cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      drdy_reg <= 1'b0;
    end else if (accept) begin
      drdy_reg <= 1'b1;
    end else if (reg_rd_i && acc_addr == ssf_pkg::ADDR_TEMP_H) begin
      drdy_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // FIFO pointers, level and overwrite
  // ----------------------------------------------------------------
  assign pop      = reg_rd_i && acc_addr == ssf_pkg::ADDR_FTEMP_H
                    && count_reg != 8'h00 && !fifo_clear;
  assign full     = (count_reg == ssf_pkg::COUNT_FULL);
  assign limit    = (fifo_ctrl_reg[ssf_pkg::CTRL_STOP_BIT] && fifo_thr_reg != 8'h00)
                    ? fifo_thr_reg : ssf_pkg::COUNT_FULL;
  assign at_limit = (count_reg >= limit) && !pop;
  assign overwrite = accept && (mode == ssf_pkg::MODE_CONT) && full && !pop;
  assign push     = accept && !fifo_clear && (!at_limit || overwrite);

  ssf_entry_mem u_mem (
    .clk_i     (clk_i),
    .wr_en_i   (push),
    .wr_addr_i (wr_ptr_reg),
    .wr_data_i ({sample_temperature_i, sample_pressure_i}),
    .rd_addr_i (rd_ptr_reg),
    .rd_data_o (head)
  );

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr_reg <= 7'h00;
      rd_ptr_reg <= 7'h00;
      count_reg  <= 8'h00;
    end else if (fifo_clear) begin
      wr_ptr_reg <= 7'h00;
      rd_ptr_reg <= 7'h00;
      count_reg  <= 8'h00;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 7'h01;
      end
      // Overwrite drops the oldest entry so the next oldest is read first
      if (pop || overwrite) begin
        rd_ptr_reg <= rd_ptr_reg + 7'h01;
      end
      if (push && !overwrite && !pop) begin
        count_reg <= count_reg + 8'h01;
      end else if (pop && !push) begin
        count_reg <= count_reg - 8'h01;
      end
    end
  end

  // Hardware set wins over the clear by bypass entry
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ovr_reg <= 1'b0;
    end else if (overwrite) begin
      ovr_reg <= 1'b1;
    end else if (fifo_clear) begin
      ovr_reg <= 1'b0;
    end
  end

  assign thr_flag = (fifo_thr_reg != 8'h00) && (count_reg >= fifo_thr_reg);

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  // In bypass the FIFO window shows the latest result in the first slot
  // Bypass reads as empty at once; the counters only clear on the next edge
  always_comb begin
    unique case (acc_addr)
      ssf_pkg::ADDR_PAD_CTRL:   rd_value = pad_ctrl_reg;
      ssf_pkg::ADDR_FIFO_CTRL:  rd_value = fifo_ctrl_reg;
      ssf_pkg::ADDR_FIFO_THR:   rd_value = fifo_thr_reg;
      ssf_pkg::ADDR_LEVEL_STAT: rd_value = fifo_clear ? 8'h00 : count_reg;
      ssf_pkg::ADDR_FLAG_STAT:  rd_value = fifo_clear ? 8'h00 : {thr_flag, ovr_reg, full, 5'h00};
      ssf_pkg::ADDR_PRESS_XL:   rd_value = press_reg[7:0];
      ssf_pkg::ADDR_PRESS_L:    rd_value = press_reg[15:8];
      ssf_pkg::ADDR_PRESS_H:    rd_value = press_reg[23:16];
      ssf_pkg::ADDR_TEMP_L:     rd_value = temp_reg[7:0];
      ssf_pkg::ADDR_TEMP_H:     rd_value = temp_reg[15:8];
      ssf_pkg::ADDR_FPRESS_XL:  rd_value = fifo_clear ? press_reg[7:0] : head[7:0];
      ssf_pkg::ADDR_FPRESS_L:   rd_value = fifo_clear ? press_reg[15:8] : head[15:8];
      ssf_pkg::ADDR_FPRESS_H:   rd_value = fifo_clear ? press_reg[23:16] : head[23:16];
      ssf_pkg::ADDR_FTEMP_L:    rd_value = fifo_clear ? temp_reg[7:0] : head[31:24];
      ssf_pkg::ADDR_FTEMP_H:    rd_value = fifo_clear ? temp_reg[15:8] : head[39:32];
      default:                  rd_value = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_value;
    end
  end

  // ----------------------------------------------------------------
  // Pad routing
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ready_interrupt_pad_o <= 1'b0;
    end else begin
      ready_interrupt_pad_o <= (pad_ctrl_reg[ssf_pkg::PAD_DRDY_BIT] && drdy_reg)
                             || (pad_ctrl_reg[ssf_pkg::PAD_THR_BIT]  && thr_flag)
                             || (pad_ctrl_reg[ssf_pkg::PAD_OVR_BIT]  && ovr_reg)
                             || (pad_ctrl_reg[ssf_pkg::PAD_FULL_BIT] && full);
    end
  end

endmodule

/* File: sim/ssf_top_monitor.sv */
`timescale 1ns/1ns
module ssf_top_monitor (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // Samples and trimming
  input  wire logic        sample_valid_i,
  input  wire logic [23:0] sample_pressure_i,
  input  wire logic [15:0] sample_temperature_i,
  input  wire logic        trim_done_o,
  input  wire logic [31:0] trim_value_o,
  // Register port and pad
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_burst_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic [7:0]  reg_rdata_o,
  input  wire logic        ready_interrupt_pad_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Burst reads reuse a stale address, so only direct reads are decoded here
  wire rd_a = reg_rd_i && !reg_burst_i;

  AST_TRIM_TIME: assert property ($rose(rstn_i) |-> ##[3:6] trim_done_o)
    else $error("trimming load late");
  AST_TRIM_HOLD: assert property (trim_done_o |=> trim_done_o && $stable(trim_value_o))
    else $error("trimming value moved");
  AST_RDATA_HOLD: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  AST_THR_BIT7: assert property (rd_a && reg_addr_i == 8'h14 |=> !reg_rdata_o[7])
    else $error("threshold bit 7 set");
  AST_COUNT_MAX: assert property (rd_a && reg_addr_i == 8'h25 |=> reg_rdata_o <= 8'h80)
    else $error("unread count above full");
  AST_FLAG_LOW: assert property (rd_a && reg_addr_i == 8'h26 |=> reg_rdata_o[4:0] == 5'h00)
    else $error("flag status low bits set");
  AST_BYPASS_EMPTY: assert property (reg_wr_i && !reg_burst_i && reg_addr_i == 8'h13
    && reg_wdata_i == 8'h00 ##1 rd_a && reg_addr_i == 8'h25 |=> reg_rdata_o == 8'h00)
    else $error("bypass left entries");
  AST_PRESS_LSB: assert property (sample_valid_i && trim_done_o ##1 rd_a &&
    reg_addr_i == 8'h28 && !sample_valid_i |=> reg_rdata_o == $past(sample_pressure_i[7:0], 2))
    else $error("pressure low byte wrong");
  AST_TEMP_MSB: assert property (sample_valid_i && trim_done_o ##1 rd_a &&
    reg_addr_i == 8'h2C && !sample_valid_i |=> reg_rdata_o == $past(sample_temperature_i[15:8], 2))
    else $error("temperature high byte wrong");
  AST_PAD_CAUSE: assert property ($rose(ready_interrupt_pad_o) |->
    $past(sample_valid_i) || $past(sample_valid_i, 2) || $past(sample_valid_i, 3) ||
    $past(reg_wr_i) || $past(reg_wr_i, 2) || $past(reg_wr_i, 3))
    else $error("pad rose without cause");
endmodule

bind ssf_top ssf_top_monitor i_mon (.clk_i, .rstn_i, .sample_valid_i, .sample_pressure_i,
  .sample_temperature_i, .trim_done_o, .trim_value_o, .reg_addr_i, .reg_burst_i, .reg_wr_i,
  .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .ready_interrupt_pad_o);

/* File: sim/ssf_host_model.sv */
`timescale 1ns/1ns
module ssf_host_model (
  // Clock
  input  wire logic       clk_i,
  // Register port
  output logic      [7:0] reg_addr_o,
  output logic            reg_burst_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [7:0] reg_wdata_o
);
  initial begin
    reg_addr_o = 8'h00;
    reg_burst_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // Entered just after an edge; held until the next edge takes it
  task automatic acc(input logic wr, input logic b, input logic [7:0] a, input logic [7:0] d);
    reg_wr_o = wr;
    reg_rd_o = !wr;
    reg_burst_o = b;
    reg_addr_o = a;
    reg_wdata_o = d;
    @(posedge clk_i);
    #1;
  endtask
  // Released lines do not keep the last value
  task automatic idle();
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = ~reg_addr_o;
    reg_wdata_o = ~reg_wdata_o;
    @(posedge clk_i);
    #1;
  endtask
  // Every mode change goes through bypass, which also empties the buffer
  task automatic set_mode(input logic [7:0] code);
    acc(1'b1, 1'b0, 8'h13, 8'h00);
    acc(1'b1, 1'b0, 8'h13, code);
  endtask
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  logic        clk_i;
  logic        rstn_i;
  logic        sample_valid_i;
  logic [23:0] sample_pressure_i;
  logic [15:0] sample_temperature_i;
  logic        interrupt_active_flag_i;
  logic [1:0]  trim_addr_o;
  logic [7:0]  trim_data_i;
  logic        trim_done_o;
  logic [31:0] trim_value_o;
  logic [7:0]  reg_addr_i;
  logic        reg_burst_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic [7:0]  reg_wdata_i;
  logic [7:0]  reg_rdata_o;
  logic        ready_interrupt_pad_o;
  logic        rd_seen;
  logic [7:0]  exp_q[$];
  logic [39:0] ent [0:129];
  logic [7:0]  ra [6] = '{8'h12, 8'h13, 8'h14, 8'h25, 8'h26, 8'h50};
  logic [7:0]  tc [4] = '{8'h05, 8'h06, 8'h04, 8'h07};
  logic [7:0]  tf [4] = '{8'h00, 8'h00, 8'h00, 8'h03};
  logic [7:0]  te [4] = '{8'h02, 8'h02, 8'h00, 8'h05};
  integer      seed;
  int          err_count;
  int          num_checks;

  ssf_top i_ssf_top (.clk_i, .rstn_i, .sample_valid_i, .sample_pressure_i, .sample_temperature_i,
    .interrupt_active_flag_i, .trim_addr_o, .trim_data_i, .trim_done_o, .trim_value_o,
    .reg_addr_i, .reg_burst_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o,
    .ready_interrupt_pad_o);
  ssf_host_model i_ssf_host_model (.clk_i, .reg_addr_o(reg_addr_i), .reg_burst_o(reg_burst_i),
    .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Trimming storage answers one cycle after the address
  always @(posedge clk_i) trim_data_i <= 8'hC0 ^ {6'h00, trim_addr_o};

  task automatic chk(input string n, input logic [39:0] e, input logic [39:0] s);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Read data is registered: compare at the falling edge after the taking edge
  always @(posedge clk_i) rd_seen <= reg_rd_i;
  always @(negedge clk_i) if (rd_seen) chk("reg_rdata_o", exp_q.pop_front(), reg_rdata_o);

  task automatic rd(input logic [7:0] a, input logic b, input logic [7:0] e);
    exp_q.push_back(e);
    i_ssf_host_model.acc(1'b0, b, a, 8'h00);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_ssf_host_model.acc(1'b1, 1'b0, a, d);
  endtask
  task automatic smp(input int k);
    logic [31:0] r;
    r = $random(seed);
    sample_pressure_i = r[23:0];
    r = $random(seed);
    sample_temperature_i = r[15:0];
    ent[k] = {sample_temperature_i, sample_pressure_i};
    sample_valid_i = 1'b1;
    @(posedge clk_i);
    #1;
  endtask
  function automatic logic [7:0] eb(input int k, input int b);
    return ent[k][8*b +: 8];
  endfunction
  // Burst over n entries starting at 0x78
  task automatic rd_ent(input int k, input int n);
    rd(8'h78, 1'b0, eb(k, 0));
    for (int j = 1; j < 5 * n; j++) rd(8'h00, 1'b1, eb(k + j / 5, j % 5));
  endtask
  task automatic burst(input int n);
    for (int i = 0; i < n; i++) smp(i);
    sample_valid_i = 1'b0;
  endtask

  initial begin
    #100000;
    err_count++;
    $display("[ERR] watchdog expected done seen timeout");
    results();
  end

  initial begin
    seed = 32'hd81d8322;
    err_count = 0;
    num_checks = 0;
    rd_seen = 1'b0;
    rstn_i = 1'b0;
    sample_valid_i = 1'b0;
    sample_pressure_i = 24'h000000;
    sample_temperature_i = 16'h0000;
    interrupt_active_flag_i = 1'b0;
    repeat (8) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    for (int i = 0; i < 20 && trim_done_o !== 1'b1; i++) @(posedge clk_i);
    #1;
    chk("trim_value_o", 32'hC3C2C1C0, trim_value_o);
    foreach (ra[i]) rd(ra[i], 1'b0, 8'h00);
    wr(8'h25, 8'hFF);
    rd(8'h25, 1'b0, 8'h00);
    wr(8'h12, 8'h10);
    wr(8'h14, 8'h83);
    rd(8'h12, 1'b0, 8'h10);
    rd(8'h14, 1'b0, 8'h03);
    i_ssf_host_model.idle();
    burst(1);
    rd(8'h28, 1'b0, eb(0, 0));
    for (int j = 1; j < 5; j++) rd(8'h00, 1'b1, eb(0, j));
    i_ssf_host_model.idle();
    burst(1);
    rd(8'h2C, 1'b0, eb(0, 4));
    i_ssf_host_model.set_mode(8'h01);
    i_ssf_host_model.idle();
    burst(130);
    repeat (2) i_ssf_host_model.idle();
    chk("ready_interrupt_pad_o", 1'b1, ready_interrupt_pad_o);
    rd(8'h25, 1'b0, 8'h80);
    rd(8'h26, 1'b0, 8'hA0);
    rd_ent(0, 2);
    rd(8'h25, 1'b0, 8'h7E);
    wr(8'h14, 8'h00);
    rd(8'h26, 1'b0, 8'h00);
    wr(8'h13, 8'h00);
    rd(8'h25, 1'b0, 8'h00);
    wr(8'h13, 8'h03);
    i_ssf_host_model.idle();
    burst(129);
    rd(8'h25, 1'b0, 8'h80);
    rd(8'h26, 1'b0, 8'h60);
    rd_ent(1, 1);
    wr(8'h12, 8'h04);
    i_ssf_host_model.idle();
    chk("ready_interrupt_pad_o", 1'b1, ready_interrupt_pad_o);
    for (int t = 0; t < 4; t++) begin
      interrupt_active_flag_i = 1'b0;
      i_ssf_host_model.set_mode(tc[t]);
      i_ssf_host_model.idle();
      burst(3);
      rd(8'h25, 1'b0, tf[t]);
      i_ssf_host_model.idle();
      interrupt_active_flag_i = 1'b1;
      repeat (2) i_ssf_host_model.idle();
      burst(2);
      rd(8'h25, 1'b0, te[t]);
      i_ssf_host_model.idle();
    end
    // Stop at threshold limits the depth to the threshold level
    wr(8'h14, 8'h02);
    i_ssf_host_model.set_mode(8'h09);
    i_ssf_host_model.idle();
    burst(4);
    rd(8'h25, 1'b0, 8'h02);
    wr(8'h12, 8'h08);
    i_ssf_host_model.idle();
    chk("ready_interrupt_pad_o", 1'b1, ready_interrupt_pad_o);
    wr(8'h12, 8'h20);
    i_ssf_host_model.idle();
    chk("ready_interrupt_pad_o", 1'b1, ready_interrupt_pad_o);
    rd(8'h2C, 1'b0, eb(3, 4));
    i_ssf_host_model.idle();
    chk("ready_interrupt_pad_o", 1'b0, ready_interrupt_pad_o);
    results();
  end
endmodule
